// *** mac_command_config_control_tb_top.sv ***
`timescale 1ns/1ps
module mac_command_config_control_tb_top;
  logic        clock_i = 1'h0, rst_i = 1'h1, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic        mdio_done_i = 1'h0, mw;
  logic [11:0] avs_address_i = 12'h0;
  logic [31:0] avs_writedata_i = 32'h0, lane_status_i = 32'h0, rd, avs_readdata_o;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [15:0] mdio_rdata_i = 16'h0, mdio_wdata_o, mwd;
  logic        avs_waitrequest_o, mdio_req_o, mdio_write_o, transmit_path_enable_o;
  logic        receive_path_enable_o, zero_quanta_pause_force_o, accept_all_destinations_o;
  logic        receive_pad_strip_o, transmit_pad_always_o, receive_fcs_pass_o;
  logic        receive_fcs_check_o, pause_frame_pass_o, pause_quanta_obey_o;
  logic        source_address_overwrite_o, fifo_flush_o, stats_clear_o;
  int          bad_count = 0, checks = 0, wcnt = 0;
  wire  [31:0] ov = {21'h0, source_address_overwrite_o, pause_quanta_obey_o,
    pause_frame_pass_o, receive_fcs_check_o, receive_fcs_pass_o, transmit_pad_always_o,
    receive_pad_strip_o, accept_all_destinations_o, zero_quanta_pause_force_o,
    receive_path_enable_o, transmit_path_enable_o};
  always #25 clock_i = ~clock_i;
  // short soft reset keeps the run brief
  mccc_regs #(.SRST_CYCLES(4)) DUT (.clock_i, .rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .lane_status_i, .mdio_done_i, .mdio_rdata_i, .mdio_req_o, .mdio_write_o, .mdio_wdata_o,
    .transmit_path_enable_o, .receive_path_enable_o, .zero_quanta_pause_force_o,
    .accept_all_destinations_o, .receive_pad_strip_o, .transmit_pad_always_o,
    .receive_fcs_pass_o, .receive_fcs_check_o, .pause_frame_pass_o, .pause_quanta_obey_o,
    .source_address_overwrite_o, .fifo_flush_o, .stats_clear_o);
  // ==========
  // mdio engine stand-in: read data is only valid with done
  always @(posedge clock_i) begin
    mdio_done_i <= 1'h0;
    mdio_rdata_i <= 16'h4110;
    if (mdio_req_o && !mdio_done_i) begin
      wcnt <= wcnt + 1;
      if (wcnt == 3) begin
        mdio_done_i <= 1'h1;
        mdio_rdata_i <= 16'hbeef;
        wcnt <= 0;
        mw <= mdio_write_o;
        mwd <= mdio_wdata_o;
      end
    end
  end
  // ==========
  // helpers
  function automatic logic [31:0] ev(input logic [31:0] w);
    return {21'h0, w[9], ~w[8], w[7], w[5], w[6] & ~w[5], 1'h1, w[5], w[4], w[2], w[1], w[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'h0) @(posedge clock_i);
    rd = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
    @(posedge clock_i);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_cfg;
    logic [31:0] w;
    chk(ov, ev(32'h0));
    for (int i = 0; i < 12; i++) begin
      w = (i < 10) ? (32'h1 << i) : ((i == 10) ? 32'h60 : 32'hffff_dfff);
      bus(1'h1, 12'h008, w, 4'hf);
      chk(ov, ev(w & 32'h3f7));
      bus(1'h0, 12'h008, 32'h0, 4'hf);
      chk(rd, w & 32'h3f7);
    end
    bus(1'h1, 12'h008, 32'h0, 4'hf);
    bus(1'h1, 12'h008, 32'hffff_dfff, 4'h2);
    bus(1'h0, 12'h008, 32'h0, 4'hf);
    chk(rd, 32'h300);
  endtask
  task automatic t_srst;
    bus(1'h1, 12'h008, 32'h13, 4'hf);
    bus(1'h1, 12'h008, 32'h2013, 4'hf);
    chk({28'h0, fifo_flush_o, stats_clear_o, transmit_path_enable_o, 1'h0}, 32'hc);
    bus(1'h0, 12'h008, 32'h0, 4'hf);
    chk(rd, 32'h2010);
    for (int n = 0; n < 40 && fifo_flush_o !== 1'h0; n++) @(posedge clock_i);
    bus(1'h0, 12'h008, 32'h0, 4'hf);
    chk(rd, 32'h10);
    bus(1'h1, 12'h008, 32'h3, 4'hf);
    rst_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    chk(ov, ev(32'h0));
    rst_i <= 1'h0;
    @(posedge clock_i);
    bus(1'h0, 12'h008, 32'h0, 4'hf);
    chk(rd, 32'h0);
  endtask
  task automatic t_lane_mdio;
    lane_status_i <= 32'h81c3_5a0f;
    repeat (4) @(posedge clock_i);
    bus(1'h1, 12'h344, 32'h0, 4'hf);
    bus(1'h0, 12'h344, 32'h0, 4'hf);
    chk(rd, 32'h81c3_5a0f);
    bus(1'h1, 12'h320, 32'h1234, 4'hf);
    chk({15'h0, mw, mwd}, 32'h1_1234);
    bus(1'h0, 12'h348, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'h0, 12'h320, 32'h0, 4'hf);
    chk({31'h0, mw}, 32'h0);
    chk(rd, 32'hbeef);
    bus(1'h0, 12'h348, 32'h0, 4'hf);
    chk(rd, 32'hbeef);
    bus(1'h1, 12'h0f0, 32'hffff_ffff, 4'hf);
    bus(1'h0, 12'h0f0, 32'h0, 4'hf);
    chk(rd, 32'h0);
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    rst_i <= 1'h0;
    @(posedge clock_i);
    t_cfg;
    t_srst;
    t_lane_mdio;
    end_of_test;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    bad_count++;
    end_of_test;
  end
endmodule

// *** mccc_defines.vh ***
`ifndef MCCC_DEFINES_VH
`define MCCC_DEFINES_VH

// =====================================================
// register byte offsets
`define MCCC_OFS_CMD_CFG      12'h008
`define MCCC_OFS_MDIO_ACCESS  12'h320
`define MCCC_OFS_LANE_STAT_B  12'h344
`define MCCC_OFS_MDIO_SHADOW  12'h348
`define MCCC_OFS_MDIO_ADDR    12'h03c

// =====================================================
// command/configuration bit positions
`define MCCC_BIT_TRANSMIT_PATH_ENABLE       0
`define MCCC_BIT_RECEIVE_PATH_ENABLE       1
`define MCCC_BIT_ZQ_PAUSE     2
`define MCCC_BIT_RSVD3        3
`define MCCC_BIT_PROMISC      4
`define MCCC_BIT_PAD_REMOVE   5
`define MCCC_BIT_FCS_PASS     6
`define MCCC_BIT_PAUSE_PASS   7
`define MCCC_BIT_PAUSE_IGNORE 8
`define MCCC_BIT_SA_OVERWRITE 9
`define MCCC_BIT_SOFT_RESET   13
`define MCCC_CFG_WIDTH        10
`define MCCC_CFG_RESET        10'h000
// bits that software may write: all low ten except reserved bit 3
`define MCCC_CFG_WMASK        10'h3f7

// =====================================================
// lane status fields
`define MCCC_LANE_DISP_LSB    0
`define MCCC_LANE_CODE_LSB    8
`define MCCC_LANE_PATT_LSB    16
`define MCCC_LANE_SYNC_LSB    24

// =====================================================
// soft reset sequence length in cycles
`define MCCC_SRST_CYCLES      8'h10
`define MCCC_WORD_ZERO        32'h0000_0000

`endif

// *** mccc_mdio_proxy.v ***
`timescale 1ns/1ps
`include "mccc_defines.vh"

module mccc_mdio_proxy (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire        start_i,
  input  wire        write_i,
  input  wire [31:0] wdata_i,
  input  wire        mdio_done_i,
  input  wire [15:0] mdio_rdata_i,
  output reg         mdio_req_o,
  output reg         mdio_write_o,
  output reg  [15:0] mdio_wdata_o,
  output reg         done_o,
  output reg  [31:0] shadow_o
);

  // =====================================================
  // one management transfer at a time; the bus stalls until done
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mdio_req_o   <= 1'b0;
      mdio_write_o <= 1'b0;
      mdio_wdata_o <= 16'h0000;
      done_o       <= 1'b0;
      shadow_o     <= `MCCC_WORD_ZERO;
    end else begin
      done_o <= 1'b0;
      if (start_i && !mdio_req_o) begin
        mdio_req_o   <= 1'b1;
        mdio_write_o <= write_i;
        mdio_wdata_o <= wdata_i[15:0];
      end else if (mdio_req_o && mdio_done_i) begin
        mdio_req_o <= 1'b0;
        done_o     <= 1'b1;
        if (!mdio_write_o)
          shadow_o <= {16'h0000, mdio_rdata_i};
      end
    end
  end

endmodule

// *** mccc_regs.v ***
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "mccc_defines.vh"


module mccc_regs #(
  parameter SRST_CYCLES = `MCCC_SRST_CYCLES
) (
  input  wire        clock_i,
  input  wire        rst_i,
  input  wire [11:0] avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire [31:0] lane_status_i,
  input  wire        mdio_done_i,
  input  wire [15:0] mdio_rdata_i,
  output reg         mdio_req_o,
  output reg         mdio_write_o,
  output reg  [15:0] mdio_wdata_o,
  output reg         transmit_path_enable_o,
  output reg         receive_path_enable_o,
  output reg         zero_quanta_pause_force_o,
  output reg         accept_all_destinations_o,
  output reg         receive_pad_strip_o,
  output reg         transmit_pad_always_o,
  output reg         receive_fcs_pass_o,
  output reg         receive_fcs_check_o,
  output reg         pause_frame_pass_o,
  output reg         pause_quanta_obey_o,
  output reg         source_address_overwrite_o,
  output reg         fifo_flush_o,
  output reg         stats_clear_o
);

  // =====================================================
  // state
  reg [`MCCC_CFG_WIDTH-1:0] cfg_r;
  reg [`MCCC_CFG_WIDTH-1:0] cfg_nxt;
  reg [31:0]                lane_meta_r;
  reg [31:0]                lane_sync_r;
  reg                       srst_pend_r;
  reg                       mdio_busy_r;
  reg                       ack_r;
  reg [31:0]                rdata_nxt;

  wire        srst_busy;
  wire        mdio_done;
  wire [31:0] shadow;
  wire        access;
  wire        mdio_hit;
  wire        srst_start;
  wire [31:0] wmask;

  assign access   = avs_read_i | avs_write_i;
  assign mdio_hit = (avs_address_i == `MCCC_OFS_MDIO_ACCESS);
  assign wmask    = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign srst_start = avs_write_i && !ack_r &&
                      (avs_address_i == `MCCC_OFS_CMD_CFG) &&
                      avs_byteenable_i[1] && avs_writedata_i[`MCCC_BIT_SOFT_RESET];

  // =====================================================
  // submodules
  mccc_soft_reset_seq #(
    .CYCLES (SRST_CYCLES)
  ) u_srst (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (srst_start),
    .busy_o  (srst_busy)
  );

  mccc_mdio_proxy u_mdio (
    .clock_i      (clock_i),
    .rst_i        (rst_i),
    .start_i      (access && mdio_hit && !mdio_busy_r && !ack_r),
    .write_i      (avs_write_i),
    .wdata_i      (avs_writedata_i),
    .mdio_done_i  (mdio_done_i),
    .mdio_rdata_i (mdio_rdata_i),
    .mdio_req_o   (),
    .mdio_write_o (),
    .mdio_wdata_o (),
    .done_o       (mdio_done),
    .shadow_o     (shadow)
  );

  // =====================================================
  // lane status pins are asynchronous: two-flop synchronisers
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      lane_meta_r <= `MCCC_WORD_ZERO;
      lane_sync_r <= `MCCC_WORD_ZERO;
    end else begin
      lane_meta_r <= lane_status_i;
      lane_sync_r <= lane_meta_r;
    end
  end

  // =====================================================
  // configuration write
  always @* begin
    cfg_nxt = cfg_r;
    if (avs_write_i && !ack_r && (avs_address_i == `MCCC_OFS_CMD_CFG)) begin
      cfg_nxt = (cfg_r & ~(wmask[`MCCC_CFG_WIDTH-1:0] & `MCCC_CFG_WMASK)) |
                (avs_writedata_i[`MCCC_CFG_WIDTH-1:0] &
                 wmask[`MCCC_CFG_WIDTH-1:0] & `MCCC_CFG_WMASK);
    end
    if (srst_start || srst_busy) begin
      cfg_nxt[`MCCC_BIT_TRANSMIT_PATH_ENABLE] = 1'b0;
      cfg_nxt[`MCCC_BIT_RECEIVE_PATH_ENABLE] = 1'b0;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= `MCCC_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // =====================================================
  // read mux
  always @* begin
    rdata_nxt = `MCCC_WORD_ZERO;
    case (avs_address_i)
      `MCCC_OFS_CMD_CFG: begin
        rdata_nxt[`MCCC_CFG_WIDTH-1:0]   = cfg_r;
        rdata_nxt[`MCCC_BIT_SOFT_RESET] = srst_pend_r;
      end
      `MCCC_OFS_LANE_STAT_B: begin
        rdata_nxt = lane_sync_r;
      end
      `MCCC_OFS_MDIO_SHADOW: begin
        rdata_nxt = shadow;
      end
      `MCCC_OFS_MDIO_ACCESS: begin
        rdata_nxt = shadow;
      end
      default: begin
        rdata_nxt = `MCCC_WORD_ZERO;
      end
    endcase
  end

  // =====================================================
  // bus handshake: plain registers answer one cycle late,
  // the management window holds waitrequest until the transfer ends
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_r             <= 1'b0;
      mdio_busy_r       <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= `MCCC_WORD_ZERO;
      srst_pend_r       <= 1'b0;
    end else begin
      ack_r             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      if (srst_start)
        srst_pend_r <= 1'b1;
      else if (!srst_busy && srst_pend_r)
        srst_pend_r <= 1'b0;
      if (access && !ack_r) begin
        if (mdio_hit) begin
          if (!mdio_busy_r) begin
            mdio_busy_r <= 1'b1;
          end else if (mdio_done) begin
            mdio_busy_r       <= 1'b0;
            ack_r             <= 1'b1;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o    <= shadow;
          end
        end else begin
          ack_r             <= 1'b1;
          avs_waitrequest_o <= 1'b0;
          avs_readdata_o    <= rdata_nxt;
        end
      end
    end
  end

  // =====================================================
  // management pins driven straight from the bus access; the proxy's own pins are left unconnected
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mdio_req_o   <= 1'b0;
      mdio_write_o <= 1'b0;
      mdio_wdata_o <= 16'h0000;
    end else if (access && mdio_hit && !mdio_busy_r && !ack_r) begin
      mdio_req_o   <= 1'b1;
      mdio_write_o <= avs_write_i;
      mdio_wdata_o <= avs_writedata_i[15:0];
    end else if (mdio_done_i) begin
      mdio_req_o   <= 1'b0;
    end
  end

  // =====================================================
  // datapath controls, registered from the next configuration word except transmit_pad_always_o, held at one; flush and clear from the soft reset
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      transmit_path_enable_o     <= 1'b0;
      receive_path_enable_o      <= 1'b0;
      zero_quanta_pause_force_o  <= 1'b0;
      accept_all_destinations_o  <= 1'b0;
      receive_pad_strip_o        <= 1'b0;
      transmit_pad_always_o      <= 1'b1;
      receive_fcs_pass_o         <= 1'b0;
      receive_fcs_check_o        <= 1'b0;
      pause_frame_pass_o         <= 1'b0;
      pause_quanta_obey_o        <= 1'b1;
      source_address_overwrite_o <= 1'b0;
      fifo_flush_o               <= 1'b0;
      stats_clear_o              <= 1'b0;
    end else begin
      transmit_path_enable_o     <= cfg_nxt[`MCCC_BIT_TRANSMIT_PATH_ENABLE];
      receive_path_enable_o      <= cfg_nxt[`MCCC_BIT_RECEIVE_PATH_ENABLE];
      zero_quanta_pause_force_o  <= cfg_nxt[`MCCC_BIT_ZQ_PAUSE];
      accept_all_destinations_o  <= cfg_nxt[`MCCC_BIT_PROMISC];
      receive_pad_strip_o        <= cfg_nxt[`MCCC_BIT_PAD_REMOVE];
      transmit_pad_always_o      <= 1'b1;
      receive_fcs_pass_o         <= cfg_nxt[`MCCC_BIT_FCS_PASS] &
                                    ~cfg_nxt[`MCCC_BIT_PAD_REMOVE];
      receive_fcs_check_o        <= cfg_nxt[`MCCC_BIT_PAD_REMOVE];
      pause_frame_pass_o         <= cfg_nxt[`MCCC_BIT_PAUSE_PASS];
      pause_quanta_obey_o        <= ~cfg_nxt[`MCCC_BIT_PAUSE_IGNORE];
      source_address_overwrite_o <= cfg_nxt[`MCCC_BIT_SA_OVERWRITE];
      fifo_flush_o               <= srst_start | srst_busy;
      stats_clear_o              <= srst_start | srst_busy;
    end
  end

endmodule

// *** mccc_regs_chk.sv ***
`timescale 1ns/1ps
// ==========
// checker for the command/config register bank
module mccc_regs_chk #(
  parameter SRST_CYCLES = 16
) (
  input wire        clock_i,
  input wire        rst_i,
  input wire [11:0] avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        mdio_req_o,
  input wire        transmit_path_enable_o,
  input wire        receive_path_enable_o,
  input wire        receive_fcs_pass_o,
  input wire        receive_fcs_check_o,
  input wire        transmit_pad_always_o,
  input wire        source_address_overwrite_o,
  input wire        fifo_flush_o
);
  localparam int SRST_MAX = SRST_CYCLES + 4;
  wire cfg_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h008;
  wire en_wr  = cfg_wr && avs_byteenable_i[0] && !avs_writedata_i[13] && !fifo_flush_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_tx; en_wr |=> transmit_path_enable_o == $past(avs_writedata_i[0]); endproperty
  a_tx: assert property (p_tx) else $error("tx enable differs from written bit");
  property p_rx; en_wr |=> receive_path_enable_o == $past(avs_writedata_i[1]); endproperty
  a_rx: assert property (p_rx) else $error("rx enable differs from written bit");
  property p_sa;
    cfg_wr && avs_byteenable_i[1] |=> source_address_overwrite_o == $past(avs_writedata_i[9]);
  endproperty
  a_sa: assert property (p_sa) else $error("sa overwrite differs");
  property p_fcs; receive_fcs_pass_o |-> !receive_fcs_check_o; endproperty
  a_fcs: assert property (p_fcs) else $error("fcs passed while pad strip on");
  property p_pad; transmit_pad_always_o; endproperty
  a_pad: assert property (p_pad) else $error("transmit padding off");
  property p_srst; fifo_flush_o && $past(fifo_flush_o) |-> !transmit_path_enable_o &&
    !receive_path_enable_o; endproperty
  a_srst: assert property (p_srst) else $error("enable on in soft reset");
  property p_send; $rose(fifo_flush_o) |-> ##[1:SRST_MAX] !fifo_flush_o; endproperty
  a_send: assert property (p_send) else $error("soft reset never ends");
  property p_mdio;
    $rose(avs_read_i || avs_write_i) && avs_address_i == 12'h320 |-> ##[1:2] mdio_req_o;
  endproperty
  a_mdio: assert property (p_mdio) else $error("no mdio request");
  property p_rsvd; avs_read_i && !avs_waitrequest_o && avs_address_i == 12'h008 |->
    !avs_readdata_o[3]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
endmodule
bind mccc_regs mccc_regs_chk #(.SRST_CYCLES(SRST_CYCLES)) u_chk (.clock_i, .rst_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_readdata_o, .avs_waitrequest_o, .mdio_req_o, .transmit_path_enable_o,
  .receive_path_enable_o, .receive_fcs_pass_o, .receive_fcs_check_o, .transmit_pad_always_o,
  .source_address_overwrite_o, .fifo_flush_o);

// *** mccc_soft_reset_seq.v ***
`timescale 1ns/1ps
`include "mccc_defines.vh"

module mccc_soft_reset_seq #(
  parameter CYCLES = `MCCC_SRST_CYCLES
) (
  input  wire clock_i,
  input  wire rst_i,
  input  wire start_i,
  output reg  busy_o
);

  reg [7:0] count_r;

  // =====================================================
  // counts the flush window; a start while busy restarts the window
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= 8'h00;
      busy_o  <= 1'b0;
    end else if (start_i) begin
      count_r <= CYCLES[7:0];
      busy_o  <= 1'b1;
    end else if (count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
      busy_o  <= (count_r != 8'h01);
    end else begin
      busy_o  <= 1'b0;
    end
  end

endmodule
